// ### cfg_hdr_pkg.sv
/*
 * Constants for the type 1 header slice at bytes 0Dh..1Ah: byte offsets,
 * reset values, field positions and the answer-path state type.
 * Assumes configuration accesses arrive as dword address plus byte enables.
 */
package cfg_hdr_pkg;

	// byte offsets of the header fields held by this block
	localparam logic [7:0] OFS_LAT_TIMER = 8'h0D;
	localparam logic [7:0] OFS_HDR_TYPE = 8'h0E;
	localparam logic [7:0] OFS_SELF_TEST = 8'h0F;
	localparam logic [7:0] OFS_CTRL_BAR = 8'h10;
	localparam logic [7:0] OFS_SCR_BAR = 8'h14;
	localparam logic [7:0] OFS_PRI_BUS = 8'h18;
	localparam logic [7:0] OFS_SEC_BUS = 8'h19;
	localparam logic [7:0] OFS_SUB_BUS = 8'h1A;

	// dword indices derived from the byte offsets
	localparam logic [5:0] DW_MISC = OFS_LAT_TIMER[7:2];
	localparam logic [5:0] DW_CTRL_BAR = OFS_CTRL_BAR[7:2];
	localparam logic [5:0] DW_SCR_BAR = OFS_SCR_BAR[7:2];
	localparam logic [5:0] DW_BUS_NUM = OFS_PRI_BUS[7:2];

	// byte lanes inside a dword
	localparam int LANE_LAT_TIMER = OFS_LAT_TIMER[1:0];
	localparam int LANE_HDR_TYPE = OFS_HDR_TYPE[1:0];
	localparam int LANE_SELF_TEST = OFS_SELF_TEST[1:0];
	localparam int LANE_PRI_BUS = OFS_PRI_BUS[1:0];
	localparam int LANE_SEC_BUS = OFS_SEC_BUS[1:0];
	localparam int LANE_SUB_BUS = OFS_SUB_BUS[1:0];

	// fixed and reset values
	localparam logic [7:0] LAT_TIMER_VAL = 8'h00;
	localparam logic [7:0] HDR_TYPE_VAL = 8'h01;
	localparam logic [7:0] SELF_TEST_VAL = 8'h00;
	localparam logic [7:0] BUS_NUM_RST = 8'h00;
	localparam logic [19:0] BAR_ADDR_RST = 20'h00000;
	localparam logic [11:0] BAR_LOW_VAL = 12'h000;

	// window layout: 20 writable bits above a 4096-byte region
	localparam int BAR_ADDR_LSB = 12;
	localparam int BAR_ADDR_BITS = 20;
	localparam int BAR_REGION_BYTES = 4096;

	// enable bit positions in the control byte held at C8h
	localparam int CTRL_WINDOW_EN_BIT = 5;
	localparam int SCR_WINDOW_EN_BIT = 6;

	typedef enum logic {
		ST_IDLE,
		ST_ANSWER
	} cfg_state_e;

endpackage : cfg_hdr_pkg

// ### bar_window.sv
/*
 * One 32-bit memory window base register with 20 writable address bits.
 * Assumes write strobe, byte enables and data come from the same clock.
 */
`timescale 1ns/100ps
module bar_window
	import cfg_hdr_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// control
	input wire logic i_enable,
	input wire logic i_wr,
	input wire logic [3:0] i_be,
	input wire logic [31:0] i_wdata,
	// value
	output logic [31:0] o_value
);

	logic [BAR_ADDR_BITS-1:0] addr_r;
	logic [BAR_ADDR_BITS-1:0] addr_nxt;

	// disabled window is held at zero so a later enable starts clean
	genvar b;
	generate
		for (b = 0; b < BAR_ADDR_BITS; b++) begin : g_bit
			always_comb begin
				if (!i_enable) begin
					addr_nxt[b] = 1'b0;
				end else if (i_wr && i_be[(b + BAR_ADDR_LSB) / 8]) begin
					addr_nxt[b] = i_wdata[b + BAR_ADDR_LSB];
				end else begin
					addr_nxt[b] = addr_r[b];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_r <= BAR_ADDR_RST;
		end else begin
			addr_r <= addr_nxt;
		end
	end

	// low twelve bits: reserved, not prefetchable, 32-bit, memory space
	assign o_value = {addr_r, BAR_LOW_VAL};

	a_bar_disabled_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!$past(i_enable) |-> o_value == 32'h00000000)
		else $error("window base not zero while disabled");

	a_bar_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_enable && i_wr && i_be[3] |=> o_value[31:24] == $past(i_wdata[31:24]))
		else $error("window base write lost");

endmodule : bar_window

// ### cfg_type1_slice.sv
/*
 * Type 1 header slice 0Dh..1Ah: fixed bytes, two memory windows, bus numbers,
 * window hit decode and type 1 configuration steering.
 * Assumes config requests, memory addresses and the C8h enable bits all come
 * from logic on i_clk_sys; the enable byte itself lives elsewhere.
 */
`timescale 1ns/100ps
module cfg_type1_slice
	import cfg_hdr_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// configuration access from the upstream requester
	input wire logic i_cfg_valid,
	input wire logic i_cfg_write,
	input wire logic [5:0] i_cfg_dword,
	input wire logic [3:0] i_cfg_be,
	input wire logic [31:0] i_cfg_wdata,
	output logic o_cfg_ack,
	output logic o_cfg_hit,
	output logic [31:0] o_cfg_rdata,
	// enable bits from the control byte at C8h
	input wire logic i_control_window_enable,
	input wire logic i_scratch_window_enable,
	// memory window decode
	input wire logic i_mem_valid,
	input wire logic [31:0] i_mem_addr,
	output logic o_ctrl_window_hit,
	output logic o_scratch_window_hit,
	// type 1 configuration steering
	input wire logic i_t1_valid,
	input wire logic [7:0] i_t1_bus,
	output logic o_t1_done,
	output logic o_t1_to_type0,
	output logic o_t1_forward,
	output logic o_t1_unclaimed
);

	// answer path
	cfg_state_e state_r;
	cfg_state_e state_nxt;
	logic hit_r;
	logic hit_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic take;
	logic wr_take;

	// bus numbers
	logic [7:0] pri_bus_r;
	logic [7:0] pri_bus_nxt;
	logic [7:0] sec_bus_r;
	logic [7:0] sec_bus_nxt;
	logic [7:0] sub_bus_r;
	logic [7:0] sub_bus_nxt;

	// windows
	logic [1:0] win_enable;
	logic [1:0] win_wr;
	logic [31:0] win_value [2];
	logic [1:0] win_hit_r;
	logic [1:0] win_hit_nxt;

	// type 1 steering
	logic t1_done_r;
	logic t1_done_nxt;
	logic t1_type0_r;
	logic t1_type0_nxt;
	logic t1_fwd_r;
	logic t1_fwd_nxt;
	logic t1_unclaimed_r;
	logic t1_unclaimed_nxt;

	assign take = (state_r == ST_IDLE) && i_cfg_valid;
	assign wr_take = take && i_cfg_write;

	assign win_enable[0] = i_control_window_enable;
	assign win_enable[1] = i_scratch_window_enable;
	assign win_wr[0] = wr_take && (i_cfg_dword == DW_CTRL_BAR);
	assign win_wr[1] = wr_take && (i_cfg_dword == DW_SCR_BAR);

	// window 0 reaches control registers, window 1 the scratchpad RAM
	genvar w;
	generate
		for (w = 0; w < 2; w++) begin : g_win
			bar_window u_bar (
				.i_clk_sys(i_clk_sys),
				.i_rstn(i_rstn),
				.i_enable(win_enable[w]),
				.i_wr(win_wr[w]),
				.i_be(i_cfg_be),
				.i_wdata(i_cfg_wdata),
				.o_value(win_value[w])
			);
			// a disabled window claims nothing, even at base zero
			always_comb begin
				win_hit_nxt[w] = i_mem_valid && win_enable[w]
					&& (i_mem_addr[31:BAR_ADDR_LSB] == win_value[w][31:BAR_ADDR_LSB]);
			end
		end
	endgenerate

	// answer path: one cycle from request to ack, requests in the ack cycle ignored
	always_comb begin
		state_nxt = state_r;
		hit_nxt = hit_r;
		rdata_nxt = rdata_r;
		unique case (state_r)
			ST_IDLE: begin
				if (i_cfg_valid) begin
					state_nxt = ST_ANSWER;
					hit_nxt = 1'b1;
					rdata_nxt = 32'h00000000;
					unique case (i_cfg_dword)
						DW_MISC: begin
							rdata_nxt[LANE_LAT_TIMER*8 +: 8] = LAT_TIMER_VAL;
							rdata_nxt[LANE_HDR_TYPE*8 +: 8] = HDR_TYPE_VAL;
							rdata_nxt[LANE_SELF_TEST*8 +: 8] = SELF_TEST_VAL;
						end
						DW_CTRL_BAR: rdata_nxt = win_value[0];
						DW_SCR_BAR: rdata_nxt = win_value[1];
						DW_BUS_NUM: begin
							rdata_nxt[LANE_PRI_BUS*8 +: 8] = pri_bus_r;
							rdata_nxt[LANE_SEC_BUS*8 +: 8] = sec_bus_r;
							rdata_nxt[LANE_SUB_BUS*8 +: 8] = sub_bus_r;
						end
						default: hit_nxt = 1'b0;
					endcase
					if (i_cfg_write) begin
						rdata_nxt = 32'h00000000;
					end
				end
			end
			ST_ANSWER: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
			hit_r <= 1'b0;
			rdata_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			hit_r <= hit_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_cfg_ack = (state_r == ST_ANSWER);
	assign o_cfg_hit = hit_r;
	assign o_cfg_rdata = rdata_r;

	// bus number bytes, written per byte lane
	always_comb begin
		pri_bus_nxt = pri_bus_r;
		sec_bus_nxt = sec_bus_r;
		sub_bus_nxt = sub_bus_r;
		if (wr_take && (i_cfg_dword == DW_BUS_NUM)) begin
			if (i_cfg_be[LANE_PRI_BUS]) begin
				pri_bus_nxt = i_cfg_wdata[LANE_PRI_BUS*8 +: 8];
			end
			if (i_cfg_be[LANE_SEC_BUS]) begin
				sec_bus_nxt = i_cfg_wdata[LANE_SEC_BUS*8 +: 8];
			end
			if (i_cfg_be[LANE_SUB_BUS]) begin
				sub_bus_nxt = i_cfg_wdata[LANE_SUB_BUS*8 +: 8];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pri_bus_r <= BUS_NUM_RST;
			sec_bus_r <= BUS_NUM_RST;
			sub_bus_r <= BUS_NUM_RST;
		end else begin
			pri_bus_r <= pri_bus_nxt;
			sec_bus_r <= sec_bus_nxt;
			sub_bus_r <= sub_bus_nxt;
		end
	end

	// type 1 steering; forward is reachable only if software breaks sub == sec
	always_comb begin
		t1_done_nxt = i_t1_valid;
		t1_type0_nxt = 1'b0;
		t1_fwd_nxt = 1'b0;
		t1_unclaimed_nxt = 1'b0;
		if (i_t1_valid) begin
			if (i_t1_bus == sec_bus_r) begin
				t1_type0_nxt = 1'b1;
			end else if ((i_t1_bus > sec_bus_r) && (i_t1_bus <= sub_bus_r)) begin
				t1_fwd_nxt = 1'b1;
			end else begin
				t1_unclaimed_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			t1_done_r <= 1'b0;
			t1_type0_r <= 1'b0;
			t1_fwd_r <= 1'b0;
			t1_unclaimed_r <= 1'b0;
			win_hit_r <= 2'b00;
		end else begin
			t1_done_r <= t1_done_nxt;
			t1_type0_r <= t1_type0_nxt;
			t1_fwd_r <= t1_fwd_nxt;
			t1_unclaimed_r <= t1_unclaimed_nxt;
			win_hit_r <= win_hit_nxt;
		end
	end

	assign o_t1_done = t1_done_r;
	assign o_t1_to_type0 = t1_type0_r;
	assign o_t1_forward = t1_fwd_r;
	assign o_t1_unclaimed = t1_unclaimed_r;
	assign o_ctrl_window_hit = win_hit_r[0];
	assign o_scratch_window_hit = win_hit_r[1];

	// checks
	a_lat_timer_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		take && !i_cfg_write && i_cfg_dword == DW_MISC |=> o_cfg_rdata[15:8] == 8'h00)
		else $error("latency timer byte not zero");

	a_hdr_type_one: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		take && !i_cfg_write && i_cfg_dword == DW_MISC |=> o_cfg_ack && o_cfg_rdata[23:16] == 8'h01)
		else $error("header type byte not 01h");

	a_self_test_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		take && !i_cfg_write && i_cfg_dword == DW_MISC |=> o_cfg_rdata[31:24] == 8'h00)
		else $error("self-test byte not zero");

	a_ctrl_hit_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_mem_valid && i_control_window_enable && i_mem_addr[31:12] == win_value[0][31:12]
		|=> o_ctrl_window_hit)
		else $error("control window address not claimed");

	a_scr_hit_decode: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_mem_valid && i_scratch_window_enable && i_mem_addr[31:12] == win_value[1][31:12]
		|=> o_scratch_window_hit)
		else $error("scratchpad window address not claimed");

	a_ctrl_read_locked: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!i_control_window_enable ##1 take && !i_cfg_write && i_cfg_dword == DW_CTRL_BAR
		|=> o_cfg_rdata == 32'h00000000)
		else $error("locked control window reads nonzero");

	a_scr_write_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!i_scratch_window_enable |=> win_value[1] == 32'h00000000)
		else $error("locked scratchpad window holds a value");

	a_low_bits_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_cfg_ack && $past(i_cfg_dword == DW_CTRL_BAR || i_cfg_dword == DW_SCR_BAR)
		|-> o_cfg_rdata[11:0] == 12'h000)
		else $error("window low bits not zero");

	a_sec_write_read: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		wr_take && i_cfg_dword == DW_BUS_NUM && i_cfg_be[1]
		##3 take && !i_cfg_write && i_cfg_dword == DW_BUS_NUM
		|=> o_cfg_rdata[15:8] == $past(i_cfg_wdata[15:8], 4))
		else $error("secondary bus number readback wrong");

	a_type0_convert: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_t1_valid && i_t1_bus == sec_bus_r |=> o_t1_done && o_t1_to_type0 && !o_t1_unclaimed)
		else $error("type 1 to secondary not converted");

	a_outside_dropped: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_t1_valid && (i_t1_bus < sec_bus_r || i_t1_bus > sub_bus_r)
		|=> o_t1_unclaimed && !o_t1_forward && !o_t1_to_type0)
		else $error("out-of-range type 1 not dropped");

	a_pri_write_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!(wr_take && i_cfg_dword == DW_BUS_NUM) |=> $stable(pri_bus_r))
		else $error("primary bus number changed without write");

endmodule : cfg_type1_slice

// ### cfg_requester.sv
/*
 * Upstream requester model: issues configuration reads and writes on the
 * slice's config port, one dword request at a time, with its own byte enables.
 * Assumes the slice's clock; the bench calls xfer through the instance.
 */
`timescale 1ns/100ps
module cfg_requester (
	// clock
	input wire logic i_clk_sys,
	// answer from the slice
	input wire logic i_ack,
	input wire logic i_hit,
	input wire logic [31:0] i_rdata,
	// request to the slice
	output logic o_valid,
	output logic o_write,
	output logic [5:0] o_dword,
	output logic [3:0] o_be,
	output logic [31:0] o_wdata
);
	initial {o_valid, o_write, o_dword, o_be, o_wdata} = '0;

	task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd,
		output logic [31:0] rd, output logic hit, output logic ok);
		int n;
		@(negedge i_clk_sys);
		{o_valid, o_write, o_dword, o_be, o_wdata} = {1'b1, wr, dw, be, wd};
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge i_clk_sys);
			ok = (i_ack === 1'b1);
		end
		rd = i_rdata;
		hit = i_hit;
		// released qualifiers flip so a stale request never looks valid
		@(negedge i_clk_sys);
		{o_valid, o_write, o_dword, o_be, o_wdata} = {1'b0, ~wr, ~dw, ~be, ~wd};
	endtask : xfer
endmodule : cfg_requester

// ### tb_cfg_type1_slice.sv
/*
 * Self-checking bench for the type 1 header slice.
 * Assumes cfg_requester drives the config port; bench drives the rest.
 */
`timescale 1ns/100ps
module tb_cfg_type1_slice;
	import cfg_hdr_pkg::*;
	logic clk_sys = 1'b0, rstn = 1'b0, ctrl_en = 1'b0, scr_en = 1'b0, mem_valid = 1'b0, t1_valid = 1'b0;
	logic [31:0] mem_addr = '0;
	logic [7:0] t1_bus = '0;
	logic cv, cw, ack, hit, ch, sh, done, to0, fwd, unc;
	logic [5:0] cdw;
	logic [3:0] cbe;
	logic [31:0] cwd, crd;
	int err_count = 0;
	int num_checks = 0;

	always #10 clk_sys = ~clk_sys;

	cfg_requester req (.i_clk_sys(clk_sys), .i_ack(ack), .i_hit(hit), .i_rdata(crd), .o_valid(cv),
		.o_write(cw), .o_dword(cdw), .o_be(cbe), .o_wdata(cwd));
	cfg_type1_slice dut (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_cfg_valid(cv), .i_cfg_write(cw),
		.i_cfg_dword(cdw), .i_cfg_be(cbe), .i_cfg_wdata(cwd), .o_cfg_ack(ack), .o_cfg_hit(hit),
		.o_cfg_rdata(crd), .i_control_window_enable(ctrl_en), .i_scratch_window_enable(scr_en),
		.i_mem_valid(mem_valid), .i_mem_addr(mem_addr), .o_ctrl_window_hit(ch), .o_scratch_window_hit(sh),
		.i_t1_valid(t1_valid), .i_t1_bus(t1_bus), .o_t1_done(done), .o_t1_to_type0(to0),
		.o_t1_forward(fwd), .o_t1_unclaimed(unc));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd,
		input logic exp_hit, input logic [31:0] exp_rd);
		logic [31:0] rd;
		logic h, ok;
		req.xfer(wr, dw, be, wd, rd, h, ok);
		chk("cfg_ack", {31'h0, ok}, 32'h1);
		if (ok !== 1'b1) end_of_test();
		chk("cfg_hit", {31'h0, h}, {31'h0, exp_hit});
		chk("cfg_rdata", rd, exp_rd);
	endtask : cfg

	task automatic probe(input logic [31:0] a, input logic [1:0] exp);
		@(negedge clk_sys);
		mem_valid = 1'b1;
		mem_addr = a;
		@(negedge clk_sys);
		mem_valid = 1'b0;
		mem_addr = ~a;
		chk("window_hit", {30'h0, ch, sh}, {30'h0, exp});
	endtask : probe

	task automatic t1(input logic [7:0] bus, input logic [3:0] exp);
		@(negedge clk_sys);
		t1_valid = 1'b1;
		t1_bus = bus;
		@(negedge clk_sys);
		t1_valid = 1'b0;
		t1_bus = ~bus;
		chk("t1_class", {28'h0, done, to0, fwd, unc}, {28'h0, exp});
	endtask : t1

	task automatic t_fixed();
		cfg(1'b0, DW_MISC, 4'h0, 32'h0, 1'b1, {SELF_TEST_VAL, HDR_TYPE_VAL, LAT_TIMER_VAL, 8'h00});
		cfg(1'b1, DW_MISC, 4'hF, 32'hFFFFFFFF, 1'b1, 32'h0);
		cfg(1'b0, DW_MISC, 4'h0, 32'h0, 1'b1, {SELF_TEST_VAL, HDR_TYPE_VAL, LAT_TIMER_VAL, 8'h00});
		cfg(1'b0, DW_BUS_NUM, 4'h0, 32'h0, 1'b1, {8'h00, {3{BUS_NUM_RST}}});
		cfg(1'b0, 6'h07, 4'h0, 32'h0, 1'b0, 32'h0);
	endtask : t_fixed

	task automatic t_bus();
		logic [7:0] buses [5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h04};
		logic [3:0] cls [5] = '{4'b1100, 4'b1010, 4'b1010, 4'b1001, 4'b1001};
		cfg(1'b1, DW_BUS_NUM, 4'hF, 32'hAA070544, 1'b1, 32'h0);
		cfg(1'b0, DW_BUS_NUM, 4'h0, 32'h0, 1'b1, 32'h00070544);
		foreach (buses[i]) t1(buses[i], cls[i]);
		// software keeps subordinate equal to secondary
		cfg(1'b1, DW_BUS_NUM, 4'h4, 32'h00050000, 1'b1, 32'h0);
		cfg(1'b0, DW_BUS_NUM, 4'h0, 32'h0, 1'b1, 32'h00050544);
		t1(8'h06, 4'b1001);
		t1(8'h05, 4'b1100);
	endtask : t_bus

	task automatic t_bar(input int w);
		logic [5:0] dw;
		dw = w ? DW_SCR_BAR : DW_CTRL_BAR;
		cfg(1'b1, dw, 4'hF, 32'hFFFFFFFF, 1'b1, 32'h0);
		cfg(1'b0, dw, 4'h0, 32'h0, 1'b1, 32'h0);
		@(negedge clk_sys);
		ctrl_en = (w == 0);
		scr_en = (w == 1);
		cfg(1'b0, dw, 4'h0, 32'h0, 1'b1, 32'h0);
		cfg(1'b1, dw, 4'hF, 32'hFFFFFFFF, 1'b1, 32'h0);
		cfg(1'b0, dw, 4'h0, 32'h0, 1'b1, 32'hFFFFF000);
		probe(32'hFFFFFFFF, w ? 2'b01 : 2'b10);
		probe(32'hFFFFEFFF, 2'b00);
		cfg(1'b1, dw, 4'h3, 32'h0000A5FF, 1'b1, 32'h0);
		cfg(1'b0, dw, 4'h0, 32'h0, 1'b1, 32'hFFFFA000);
		@(negedge clk_sys);
		ctrl_en = 1'b0;
		scr_en = 1'b0;
		cfg(1'b0, dw, 4'h0, 32'h0, 1'b1, 32'h0);
		probe(32'hFFFFA000, 2'b00);
	endtask : t_bar

	initial begin
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1'b1;
		t_fixed();
		t_bus();
		t_bar(0);
		t_bar(1);
		end_of_test();
	end
endmodule : tb_cfg_type1_slice
